//--- hw/irq_pkg.sv
// shared constants for the interrupt prioritiser and its core-side end
package irq_pkg;
    localparam int NUM_WAKE_PINS  = 5;
    localparam int NUM_PLAIN_PINS = 6;
    localparam int NUM_PINS       = 12;   // wake pins, plain pins, nmi on top
    localparam int NMI_BIT        = 11;
    localparam int NUM_PERIPH     = 32;
    localparam int NUM_WAKE_SRC   = 6;    // five wake pins plus the rtc event
    localparam int RTC_WAKE       = 5;
    localparam int FIRST_PLAIN    = 6;    // source numbers 1..5 are wake pins
    localparam int FIRST_PERIPH   = 12;
    localparam int NUM_SRC        = 44;   // 0 = software set
    localparam int NUM_W          = 6;
    localparam int LVL_W          = 3;
    localparam int VEC_W          = 10;
    localparam int VEC_SHIFT      = 4;
    localparam int LINK_AW        = 8;
    localparam int SW_AW          = 9;
    localparam int DATA_W         = 32;
    localparam int WCODE_W        = 3;

    // detection modes, shared by polarity field and wake edge select
    localparam logic [1:0] MODE_LOW  = 2'h0;
    localparam logic [1:0] MODE_HIGH = 2'h1;
    localparam logic [1:0] MODE_FALL = 2'h2;
    localparam logic [1:0] MODE_RISE = 2'h3;

    // device register map (byte addresses on the link)
    localparam logic [7:0] CTL_BASE   = 8'h00;  // one source_mode_control per source
    localparam logic [7:0] WAKE_BASE  = 8'hC0;  // one wake_source_control per wake source
    localparam logic [7:0] CLR_ADDR   = 8'hE0;  // pending_clear_reg
    localparam logic [7:0] WCLR_ADDR  = 8'hE4;  // wake_clear_reg
    localparam logic [7:0] STAT_ADDR  = 8'hE8;
    localparam logic [7:0] PLO_ADDR   = 8'hF0;
    localparam logic [7:0] PHI_ADDR   = 8'hF4;
    localparam logic [7:0] STBY_ADDR  = 8'hF8;

    // source_mode_control fields
    localparam int LVL_LSB = 0;
    localparam int POL_LSB = 4;
    localparam int DMA_BIT = 8;
    localparam int CTL_W   = 9;
    // wake_source_control fields
    localparam int WEDGE_LSB = 0;
    localparam int WEN_BIT   = 4;
    localparam int WCTL_W    = 5;
    // status register fields
    localparam int ST_NUM_LSB  = 0;
    localparam int ST_LVL_LSB  = 8;
    localparam int ST_REQ_BIT  = 11;
    localparam int ST_STBY_BIT = 12;
    localparam int ST_CGR_LSB  = 16;

    // core-side registers (software port addresses)
    localparam int          LOCAL_BIT    = 8;
    localparam logic [8:0]  CORE_STATUS  = 9'h100;
    localparam logic [8:0]  CORE_TAKEN   = 9'h104;
    localparam int          IEN_BIT      = 0;
    localparam int          MASK_LSB     = 13;
    localparam int          TAKEN_LVL_LSB = 12;
endpackage

//--- hw/irq_link_if.sv
// link between the interrupt prioritiser and the processor core end
`timescale 1ns/1ps
interface irq_link_if;
    import irq_pkg::*;
    logic [LINK_AW-1:0] addr;
    logic [DATA_W-1:0]  wdata;
    logic               wr;
    logic               rd;
    logic [DATA_W-1:0]  rdata;
    logic               req;
    logic [LVL_W-1:0]   level;
    logic [VEC_W-1:0]   vector;
    logic               nmi;

    modport dev  (input addr, wdata, wr, rd, output rdata, req, level, vector, nmi);
    modport core (output addr, wdata, wr, rd, input rdata, req, level, vector, nmi);
endinterface

//--- hw/src_detect.sv
// polarity and edge/level detector for one interrupt input
`timescale 1ns/1ps
module src_detect
    import irq_pkg::*;
(
    input  wire logic       clk,   // system clock
    input  wire logic       rstn,  // async reset, active low
    input  wire logic       din,   // input, already in the clk domain
    input  wire logic [1:0] mode,  // low, high, falling or rising
    output logic            hit    // level: active; edge: one-cycle pulse
);
    typedef struct packed {
        logic prev;
    } det_t;

    det_t s_r;
    det_t s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.prev = din;
        case (mode)
            MODE_LOW:  hit = ~din;
            MODE_HIGH: hit = din;
            MODE_FALL: hit = s_r.prev & ~din;
            MODE_RISE: hit = ~s_r.prev & din;
            default:   hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

//--- hw/irq_prioritiser.sv
// interrupt prioritiser with clock_generator_unit wake logic
`timescale 1ns/1ps
//
// Overview of operation
// - per-source level, seven levels, zero blocks
// - eleven maskable pins, thirty-two peripherals, vector each; nmi pin has none
// - interrupt events can trigger DMA
// - only five pins and rtc wake
// - per-pin polarity and edge or level
// - wake-enabled source uses wake edge select
// - wake enable bit; code 10 falling edge
// - software sets polarity high when wake-enabled
// - level decides service after leaving standby
// - non-wake pin governed by controller settings only
// - software sets rtc high level, rising edge
// - dma done falling edge, rtc high level, others rising
// - present only highest-priority pending request
// - clear code clears that pending edge request; level requests ignore it
// - wake clear code clears latched wake
// - level 000 disables; documented enable order
// - software disables wake source in order
// - core holds mask and global enable
// - level source held until processing begins
// - source 0 posts while level non-zero
module irq_prioritiser
    import irq_pkg::*;
#(
    parameter logic [NUM_PERIPH-1:0] DMA_DONE_MASK = 32'h0000_0003, // peripherals that are dma done
    parameter int                    RTC_IDX       = 31              // peripheral index of the rtc
)(
    input  wire logic                      clk,          // system clock
    input  wire logic                      rstn,         // async reset, active low
    irq_link_if.dev                        link,         // core side
    input  wire logic [NUM_WAKE_PINS-1:0]  wake_pins,    // wake_capable_pins, asynchronous
    input  wire logic [NUM_PLAIN_PINS-1:0] plain_pins,   // plain_external_pins, asynchronous
    input  wire logic                      nmi_pin,      // non-maskable pin, asynchronous
    input  wire logic [NUM_PERIPH-1:0]     periph_irq,   // on-chip sources, clk domain
    input  wire logic                      stop_mode,    // 1 = stop, 0 = sleep while in standby
    output logic                           standby_r,    // standby in force
    output logic                           osc_stop_r,   // oscillator halted (stop mode)
    output logic [NUM_PERIPH-1:0]          dma_trig_r    // dma trigger pulses, one per peripheral
);
    if (RTC_IDX < 0 || RTC_IDX >= NUM_PERIPH) begin : g_bad_rtc
        $error("rtc index outside peripheral range");
    end
    if (NUM_SRC > (1 << NUM_W)) begin : g_bad_num
        $error("source count exceeds clear code width");
    end

    typedef struct packed {
        logic [NUM_PINS-1:0]                   sp1;
        logic [NUM_PINS-1:0]                   sp2;
        logic [NUM_SRC-1:0][CTL_W-1:0]         ctl;
        logic [NUM_WAKE_SRC-1:0][WCTL_W-1:0]   wctl;
        logic [NUM_SRC-1:0]                    pend;
        logic [NUM_WAKE_SRC-1:0]               cg_req;
        logic                                  standby;
        logic                                  osc_stop;
        logic [NUM_PERIPH-1:0]                 dma;
        logic [DATA_W-1:0]                     rdata;
        logic                                  req;
        logic [LVL_W-1:0]                      lvl;
        logic [NUM_W-1:0]                      num;
        logic                                  nmi;
    } dev_t;

    dev_t s_r;
    dev_t s_nxt;

    logic [NUM_SRC-1:0]      src_in;
    logic [NUM_SRC-1:0][1:0] src_mode;
    logic [NUM_SRC-1:0]      src_hit;
    logic [NUM_WAKE_SRC-1:0] wk_in;
    logic [NUM_WAKE_SRC-1:0] wk_hit;

    // routing of inputs to the controller detectors
    always_comb begin
        src_in   = '0;
        src_mode = '0;
        wk_in    = {periph_irq[RTC_IDX], s_r.sp2[NUM_WAKE_PINS-1:0]};
        for (int k = 0; k < NUM_WAKE_PINS; k++) begin
            if (s_r.wctl[k][WEN_BIT]) begin
                src_in[k+1]   = s_r.cg_req[k];
                src_mode[k+1] = MODE_HIGH;
            end else begin
                src_in[k+1]   = s_r.sp2[k];
                src_mode[k+1] = s_r.ctl[k+1][POL_LSB +: 2];
            end
        end
        for (int k = 0; k < NUM_PLAIN_PINS; k++) begin
            src_in[FIRST_PLAIN+k]   = s_r.sp2[NUM_WAKE_PINS+k];
            src_mode[FIRST_PLAIN+k] = s_r.ctl[FIRST_PLAIN+k][POL_LSB +: 2];
        end
        for (int p = 0; p < NUM_PERIPH; p++) begin
            src_in[FIRST_PERIPH+p]   = periph_irq[p];
            src_mode[FIRST_PERIPH+p] = DMA_DONE_MASK[p] ? MODE_FALL : MODE_RISE;
            if (p == RTC_IDX) begin
                // rtc always passes through the clock generator latch
                src_in[FIRST_PERIPH+p]   = s_r.cg_req[RTC_WAKE];
                src_mode[FIRST_PERIPH+p] = MODE_HIGH;
            end
        end
    end

    for (genvar i = 1; i < NUM_SRC; i++) begin : g_src
        src_detect u_det (
            .clk  (clk),
            .rstn (rstn),
            .din  (src_in[i]),
            .mode (src_mode[i]),
            .hit  (src_hit[i])
        );
    end
    assign src_hit[0] = 1'b0;

    for (genvar k = 0; k < NUM_WAKE_SRC; k++) begin : g_wake
        src_detect u_det (
            .clk  (clk),
            .rstn (rstn),
            .din  (wk_in[k]),
            .mode (s_r.wctl[k][WEDGE_LSB +: 2]),
            .hit  (wk_hit[k])
        );
    end

    logic [LINK_AW-1:0] widx;
    logic [LVL_W-1:0]   best_lvl;
    logic [NUM_W-1:0]   best_num;
    logic               wake_any;
    logic [1:0]         m;

    always_comb begin
        s_nxt     = s_r;
        widx      = link.addr >> 2;
        best_lvl  = '0;
        best_num  = '0;
        wake_any  = 1'b0;
        m         = MODE_LOW;
        s_nxt.sp1 = {nmi_pin, plain_pins, wake_pins};
        s_nxt.sp2 = s_r.sp1;
        s_nxt.nmi = s_r.sp2[NMI_BIT];
        s_nxt.dma = '0;

        if (link.wr) begin
            if (link.addr < CTL_BASE + LINK_AW'(NUM_SRC * 4)) begin
                s_nxt.ctl[widx] = link.wdata[CTL_W-1:0];
            end else if (link.addr >= WAKE_BASE && link.addr < WAKE_BASE + LINK_AW'(NUM_WAKE_SRC * 4)) begin
                s_nxt.wctl[widx - (WAKE_BASE >> 2)] = link.wdata[WCTL_W-1:0];
            end else if (link.addr == STBY_ADDR) begin
                s_nxt.standby  = 1'b1;
                s_nxt.osc_stop = stop_mode;
            end
        end

        // wake latches: only the five low pins and the rtc exist here
        for (int k = 0; k < NUM_WAKE_SRC; k++) begin
            s_nxt.cg_req[k] = s_r.cg_req[k];
            if (link.wr && link.addr == WCLR_ADDR && link.wdata[WCODE_W-1:0] == WCODE_W'(k)) begin
                s_nxt.cg_req[k] = 1'b0;
            end
            if (wk_hit[k] && (s_r.wctl[k][WEN_BIT] || k == RTC_WAKE)) begin
                s_nxt.cg_req[k] = 1'b1;                                // set wins
            end
            if (s_r.cg_req[k] && s_r.wctl[k][WEN_BIT]) begin
                wake_any = 1'b1;
            end
        end
        if (wake_any) begin
            s_nxt.standby  = 1'b0;
            s_nxt.osc_stop = 1'b0;
        end

        // pending: edge requests latch, level requests follow the input
        for (int i = 1; i < NUM_SRC; i++) begin
            m = src_mode[i];
            if (m == MODE_FALL || m == MODE_RISE) begin
                if (link.wr && link.addr == CLR_ADDR && link.wdata[NUM_W-1:0] == NUM_W'(i)) begin
                    s_nxt.pend[i] = 1'b0;
                end
                if (src_hit[i]) begin
                    s_nxt.pend[i] = 1'b1;
                end
            end else begin
                s_nxt.pend[i] = src_hit[i];
            end
        end
        s_nxt.pend[0] = |s_r.ctl[0][LVL_LSB +: LVL_W];

        for (int p = 0; p < NUM_PERIPH; p++) begin
            s_nxt.dma[p] = src_hit[FIRST_PERIPH+p] & ~s_r.pend[FIRST_PERIPH+p]
                         & s_r.ctl[FIRST_PERIPH+p][DMA_BIT];
        end

        // strict compare keeps the lowest number on equal levels
        for (int i = 0; i < NUM_SRC; i++) begin
            if (s_r.pend[i] && s_r.ctl[i][LVL_LSB +: LVL_W] > best_lvl) begin
                best_lvl = s_r.ctl[i][LVL_LSB +: LVL_W];
                best_num = NUM_W'(i);
            end
        end
        s_nxt.req = |best_lvl;
        s_nxt.lvl = best_lvl;
        s_nxt.num = best_num;

        s_nxt.rdata = '0;
        if (link.rd) begin
            if (link.addr < CTL_BASE + LINK_AW'(NUM_SRC * 4)) begin
                s_nxt.rdata[CTL_W-1:0] = s_r.ctl[widx];
            end else if (link.addr >= WAKE_BASE && link.addr < WAKE_BASE + LINK_AW'(NUM_WAKE_SRC * 4)) begin
                s_nxt.rdata[WCTL_W-1:0] = s_r.wctl[widx - (WAKE_BASE >> 2)];
            end else begin
                case (link.addr)
                    STAT_ADDR: begin
                        s_nxt.rdata[ST_NUM_LSB +: NUM_W]        = s_r.num;
                        s_nxt.rdata[ST_LVL_LSB +: LVL_W]        = s_r.lvl;
                        s_nxt.rdata[ST_REQ_BIT]                 = s_r.req;
                        s_nxt.rdata[ST_STBY_BIT]                = s_r.standby;
                        s_nxt.rdata[ST_CGR_LSB +: NUM_WAKE_SRC] = s_r.cg_req;
                    end
                    PLO_ADDR:  s_nxt.rdata = s_r.pend[DATA_W-1:0];
                    PHI_ADDR:  s_nxt.rdata[NUM_SRC-DATA_W-1:0] = s_r.pend[NUM_SRC-1:DATA_W];
                    STBY_ADDR: s_nxt.rdata[0] = s_r.standby;
                    default:   s_nxt.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.rdata  = s_r.rdata;
    assign link.req    = s_r.req;
    assign link.level  = s_r.lvl;
    assign link.vector = {s_r.num, {VEC_SHIFT{1'b0}}};
    assign link.nmi    = s_r.nmi;
    assign standby_r   = s_r.standby;
    assign osc_stop_r  = s_r.osc_stop;
    assign dma_trig_r  = s_r.dma;
endmodule

//--- hw/core_irq_end.sv
// processor core end: mask level, global enable, register port
`timescale 1ns/1ps
module core_irq_end
    import irq_pkg::*;
(
    input  wire logic              clk,          // system clock
    input  wire logic              rstn,         // async reset, active low
    irq_link_if.core               link,         // prioritiser side
    input  wire logic [SW_AW-1:0]  sw_addr,      // software byte address
    input  wire logic [DATA_W-1:0] sw_wdata,     // software write data
    input  wire logic              sw_wr,        // write strobe
    input  wire logic              sw_rd,        // read strobe
    output logic [DATA_W-1:0]      sw_rdata,     // read data, cycle after sw_rd
    output logic                   cpu_irq_r,    // request accepted by the core
    output logic [VEC_W-1:0]       cpu_vector_r, // vector of that request
    output logic                   cpu_nmi_r     // non-maskable request
);
    typedef struct packed {
        logic [LVL_W-1:0]  mask;
        logic              ien;
        logic              sel_dev;
        logic [DATA_W-1:0] rdata;
        logic              irq;
        logic [VEC_W-1:0]  vec;
        logic [LVL_W-1:0]  tlvl;
        logic              nmi;
    } core_t;

    core_t s_r;
    core_t s_nxt;

    logic local_acc;
    assign local_acc = sw_addr[LOCAL_BIT];

    // device accesses pass straight through so read data keeps its one-cycle latency
    assign link.addr  = sw_addr[LINK_AW-1:0];
    assign link.wdata = sw_wdata;
    assign link.wr    = sw_wr & ~local_acc;
    assign link.rd    = sw_rd & ~local_acc;

    always_comb begin
        s_nxt       = s_r;
        s_nxt.rdata = '0;
        s_nxt.nmi   = link.nmi;
        if (sw_wr && sw_addr == CORE_STATUS) begin
            s_nxt.mask = sw_wdata[MASK_LSB +: LVL_W];
            s_nxt.ien  = sw_wdata[IEN_BIT];
        end
        if (sw_rd) begin
            s_nxt.sel_dev = ~local_acc;
            case (sw_addr)
                CORE_STATUS: begin
                    s_nxt.rdata[MASK_LSB +: LVL_W] = s_r.mask;
                    s_nxt.rdata[IEN_BIT]           = s_r.ien;
                end
                CORE_TAKEN: begin
                    s_nxt.rdata[VEC_W-1:0]              = s_r.vec;
                    s_nxt.rdata[TAKEN_LVL_LSB +: LVL_W] = s_r.tlvl;
                end
                default: s_nxt.rdata = '0;
            endcase
        end
        // accept only when enabled and above the mask
        s_nxt.irq = link.req & s_r.ien & (link.level > s_r.mask);
        if (s_nxt.irq) begin
            s_nxt.vec  = link.vector;
            s_nxt.tlvl = link.level;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sw_rdata     = s_r.sel_dev ? link.rdata : s_r.rdata;
    assign cpu_irq_r    = s_r.irq;
    assign cpu_vector_r = s_r.vec;
    assign cpu_nmi_r    = s_r.nmi;
endmodule

//--- bench/irq_monitor.sv
// link-level assertions between the prioritiser and the core end
`timescale 1ns/1ps
module irq_monitor
    import irq_pkg::*;
(
    input wire logic               clk,    // system clock
    input wire logic               rstn,   // async reset, active low
    input wire logic [LINK_AW-1:0] addr,   // link address
    input wire logic [DATA_W-1:0]  wdata,  // link write data
    input wire logic               wr,     // link write strobe
    input wire logic               rd,     // link read strobe
    input wire logic [DATA_W-1:0]  rdata,  // link read data
    input wire logic               req,    // request presented
    input wire logic [LVL_W-1:0]   level,  // level of that request
    input wire logic [VEC_W-1:0]   vector, // vector of that request
    input wire logic               nmi     // non-maskable request
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_LVL_NZ: assert property (req |-> level != 3'h0)
        else $error("request presented at level zero");
    AST_VEC_ALIGN: assert property (req |-> vector[VEC_SHIFT-1:0] == 4'h0)
        else $error("vector not a source number times sixteen");
    AST_VEC_RANGE: assert property (req |-> vector[9:4] < NUM_SRC)
        else $error("vector beyond the last source");
    AST_SW_SET: assert property (wr && addr == CTL_BASE && wdata[2:0] != 3'h0 |-> ##[1:4] req)
        else $error("software set source not posted");
    AST_SW_TOP: assert property (wr && addr == CTL_BASE && wdata[2:0] == 3'h7
        |-> ##[1:4] (req && level == 3'h7 && vector == 10'h000))
        else $error("level seven source zero not presented");
    // a source whose level is zeroed must leave the link within two cycles
    AST_LVL0_DROP: assert property (wr && req && addr < WAKE_BASE && addr[7:2] == vector[9:4]
        && wdata[2:0] == 3'h0 |-> ##2 (!req || vector != $past(vector, 2)))
        else $error("zero level source still presented");
    AST_STAT: assert property (rd && addr == STAT_ADDR && req
        |=> rdata[11:8] == {1'b1, $past(level)} && rdata[5:0] == $past(vector[9:4]))
        else $error("status does not match presented request");
    AST_RD_IDLE: assert property (!rd |=> rdata == 32'h0)
        else $error("read data outside the read answer cycle");
endmodule

//--- bench/tb.sv
// self-checking bench: prioritiser and core end joined by the link
`timescale 1ns/1ps
module tb
    import irq_pkg::*;
;
    logic                      clk, rstn, sw_wr, sw_rd, stop_mode, nmi_pin;
    logic                      cpu_irq_r, cpu_nmi_r, standby_r, osc_stop_r;
    logic [SW_AW-1:0]          sw_addr;
    logic [DATA_W-1:0]         sw_wdata, sw_rdata, rv;
    logic [VEC_W-1:0]          cpu_vector_r;
    logic [NUM_WAKE_PINS-1:0]  wake_pins;
    logic [NUM_PLAIN_PINS-1:0] plain_pins;
    logic [NUM_PERIPH-1:0]     periph_irq, dma_trig_r, dma_seen;
    int                        error_cnt, n_checks, dma_cnt;

    irq_link_if link_if ();
    irq_prioritiser irq_prioritiser_inst (.clk(clk), .rstn(rstn), .link(link_if), .wake_pins(wake_pins),
        .plain_pins(plain_pins), .nmi_pin(nmi_pin), .periph_irq(periph_irq), .stop_mode(stop_mode),
        .standby_r(standby_r), .osc_stop_r(osc_stop_r), .dma_trig_r(dma_trig_r));
    core_irq_end core_irq_end_inst (.clk(clk), .rstn(rstn), .link(link_if), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .cpu_irq_r(cpu_irq_r),
        .cpu_vector_r(cpu_vector_r), .cpu_nmi_r(cpu_nmi_r));
    irq_monitor irq_monitor_inst (.clk(clk), .rstn(rstn), .addr(link_if.addr), .wdata(link_if.wdata),
        .wr(link_if.wr), .rd(link_if.rd), .rdata(link_if.rdata), .req(link_if.req),
        .level(link_if.level), .vector(link_if.vector), .nmi(link_if.nmi));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // dma pulses are one cycle wide, so they are counted as they pass
    always @(posedge clk) begin
        if (dma_trig_r != 32'h0) begin
            dma_cnt  <= dma_cnt + 1;
            dma_seen <= dma_trig_r;
        end
    end

    function automatic logic [8:0] ctl(input int n);
        return {1'b0, CTL_BASE} + 9'(4 * n);
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_wr    <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [8:0] a, input logic [31:0] msk, input logic [31:0] exp);
        @(posedge clk);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 rv = sw_rdata;
        check(name, rv & msk, exp);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        error_cnt++;
        final_report();
    end

    initial begin
        error_cnt = 0; n_checks = 0; dma_cnt = 0; dma_seen = 32'h0;
        rstn = 1'b0; sw_wr = 1'b0; sw_rd = 1'b0; sw_addr = 9'h000; sw_wdata = 32'h0;
        wake_pins = 5'h1F; plain_pins = 6'h3F; nmi_pin = 1'b0; periph_irq = 32'h0; stop_mode = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        // the rtc latch sees its low-level reset mode while the rtc line idles low
        rd_chk("status", {1'b0, STAT_ADDR}, 32'hFFFF_FFFF, 32'h0020_0000);
        rd_chk("unmapped", 9'h1FC, 32'hFFFF_FFFF, 32'h0);
        wr_reg(CORE_STATUS, 32'h1);
        rd_chk("core status", CORE_STATUS, 32'hFFFF_FFFF, 32'h1);
        $display("test reset done");

        wr_reg(ctl(14), 32'h5);
        wr_reg(ctl(15), 32'h5);
        @(posedge clk) periph_irq[3:2] <= 2'h3;
        @(posedge clk) periph_irq[3:2] <= 2'h0;
        cyc(4);
        check("vector", link_if.vector, 10'(14 << VEC_SHIFT));
        check("cpu irq", cpu_irq_r, 1'b1);
        rd_chk("pending", {1'b0, PLO_ADDR}, 32'h0000_C000, 32'h0000_C000);
        rd_chk("status", {1'b0, STAT_ADDR}, 32'h0000_0FFF, 32'h0000_0D0E);
        wr_reg(ctl(16), 32'h6);
        @(posedge clk) periph_irq[4] <= 1'b1;
        cyc(4);
        check("vector", link_if.vector, 10'(16 << VEC_SHIFT));
        wr_reg({1'b0, CLR_ADDR}, 32'd16);
        cyc(3);
        check("vector", link_if.vector, 10'(14 << VEC_SHIFT));
        wr_reg(CORE_STATUS, 32'h0000_A001);
        cyc(3);
        check("cpu irq", cpu_irq_r, 1'b0);
        wr_reg(CORE_STATUS, 32'h0000_8001);
        cyc(3);
        check("cpu irq", cpu_irq_r, 1'b1);
        check("cpu vector", cpu_vector_r, 10'(14 << VEC_SHIFT));
        wr_reg(ctl(14), 32'h0);
        cyc(3);
        check("vector", link_if.vector, 10'(15 << VEC_SHIFT));
        wr_reg(ctl(15), 32'h0);
        wr_reg(ctl(16), 32'h0);
        $display("test priority done");

        wr_reg(ctl(0), 32'h7);
        cyc(3);
        check("sw set", {link_if.req, link_if.level, link_if.vector}, {1'b1, 3'h7, 10'h000});
        wr_reg(ctl(0), 32'h0);
        cyc(3);
        check("req", link_if.req, 1'b0);
        $display("test software set done");

        wr_reg(ctl(17), 32'h103);
        wr_reg(ctl(12), 32'h3);
        @(posedge clk);
        periph_irq[5] <= 1'b1;
        periph_irq[0] <= 1'b1;
        cyc(4);
        check("dma count", dma_cnt, 32'd1);
        check("dma bits", dma_seen, 32'h0000_0020);
        rd_chk("pending", {1'b0, PLO_ADDR}, 32'h0002_1000, 32'h0002_0000);
        @(posedge clk) periph_irq[0] <= 1'b0;
        cyc(4);
        rd_chk("pending", {1'b0, PLO_ADDR}, 32'h0000_1000, 32'h0000_1000);
        wr_reg(ctl(12), 32'h0);
        wr_reg(ctl(17), 32'h0);
        $display("test dma done");

        // plain pin 2 walks through all four detection modes
        for (int m = 0; m < 4; m++) begin
            @(posedge clk) plain_pins[2] <= ~m[0];
            cyc(6);
            wr_reg(ctl(8), {26'h0, 2'(m), 4'h1});
            wr_reg({1'b0, CLR_ADDR}, 32'd8);
            cyc(2);
            rd_chk("idle pending", {1'b0, PLO_ADDR}, 32'h100, 32'h0);
            @(posedge clk) plain_pins[2] <= m[0];
            cyc(6);
            rd_chk("active pending", {1'b0, PLO_ADDR}, 32'h100, 32'h100);
            @(posedge clk) plain_pins[2] <= ~m[0];
            cyc(6);
            rd_chk("released pending", {1'b0, PLO_ADDR}, 32'h100, {23'h0, m[1], 8'h0});
        end
        wr_reg(ctl(8), 32'h0);
        $display("test modes done");

        wr_reg({1'b0, WAKE_BASE} + 9'd20, 32'h3);
        wr_reg({1'b0, WCLR_ADDR}, 32'd5);
        wr_reg({1'b0, WAKE_BASE}, 32'h2);
        wr_reg({1'b0, WCLR_ADDR}, 32'h0);
        wr_reg({1'b0, WAKE_BASE}, 32'h12);
        wr_reg(ctl(1), 32'h15);
        wr_reg({1'b0, CLR_ADDR}, 32'h1);
        wr_reg(ctl(9), 32'h22);
        @(posedge clk) stop_mode <= 1'b1;
        wr_reg({1'b0, STBY_ADDR}, 32'h1);
        cyc(2);
        check("standby", {standby_r, osc_stop_r}, 2'h3);
        @(posedge clk) plain_pins[3] <= 1'b0;
        cyc(8);
        check("standby", {standby_r, osc_stop_r}, 2'h3);
        @(posedge clk) wake_pins[0] <= 1'b0;
        cyc(8);
        check("standby", {standby_r, osc_stop_r}, 2'h0);
        check("vector", link_if.vector, 10'(1 << VEC_SHIFT));
        rd_chk("wake latch", {1'b0, STAT_ADDR}, 32'h0001_0000, 32'h0001_0000);
        wr_reg({1'b0, WCLR_ADDR}, 32'h0);
        cyc(3);
        rd_chk("wake latch", {1'b0, STAT_ADDR}, 32'h0001_0000, 32'h0);
        check("vector", link_if.vector, 10'(9 << VEC_SHIFT));
        wr_reg(CORE_STATUS, 32'h0);
        wr_reg(ctl(1), 32'h0);
        wr_reg({1'b0, CLR_ADDR}, 32'h1);
        wr_reg({1'b0, WAKE_BASE}, 32'h2);
        wr_reg({1'b0, WCLR_ADDR}, 32'h0);
        cyc(3);
        check("cpu irq", cpu_irq_r, 1'b0);
        rd_chk("wake ctl", {1'b0, WAKE_BASE}, 32'h0000_001F, 32'h0000_0002);
        @(posedge clk) stop_mode <= 1'b0;
        wr_reg({1'b0, STBY_ADDR}, 32'h1);
        cyc(2);
        check("sleep", {standby_r, osc_stop_r}, 2'h2);
        @(posedge clk) nmi_pin <= 1'b1;
        cyc(6);
        check("nmi", cpu_nmi_r, 1'b1);
        $display("test wake done");
        final_report();
    end
endmodule
